// >>> core/ccrs_consts.svh
`ifndef CCRS_CONSTS_SVH
`define CCRS_CONSTS_SVH

// ==========================================================
// Reset sequencing counts
`define CCRS_RST_CYCLES 4096
`define CCRS_RST_CNT_W 13
`define CCRS_TAIL_CYCLES 2'h2
`define CCRS_TAIL_W 2

// ==========================================================
// Core clock rate, ns per cycle
`define CCRS_SYS_CLK_NS 40

// ==========================================================
// Core-to-input ratio straps and multipliers
`define CCRS_STRAP_W 2
`define CCRS_STRAP_16 2'h0
`define CCRS_STRAP_32 2'h1
`define CCRS_STRAP_6 2'h2
`define CCRS_MULT_W 6
`define CCRS_MULT_6 6'h06
`define CCRS_MULT_16 6'h10
`define CCRS_MULT_32 6'h20
`define CCRS_MULT_DEFAULT 6'h10

// ==========================================================
// Peripheral divider ratio width
`define CCRS_RATIO_W 16

`endif

// >>> core/ccrs_pkg.sv
package ccrs_pkg;
  // ==========================================================
  // Reset sequencer states, one-hot
  typedef enum logic [3:0] {
    CCRS_ST_HOLD = 4'b0001,
    CCRS_ST_COUNT = 4'b0010,
    CCRS_ST_TAIL = 4'b0100,
    CCRS_ST_RUN = 4'b1000
  } ccrs_state_type;
endpackage

// >>> core/ccrs_div_if.sv
interface ccrs_div_if #(parameter int RATIO_W = 16);
  logic [RATIO_W-1:0] ratio;
  logic run;
  logic clk_out;
  modport ctrl (output ratio, output run, input clk_out);
  modport div (input ratio, input run, output clk_out);
endinterface

// >>> core/ccrs_divider.sv
`include "ccrs_consts.svh"

module ccrs_divider #(
  parameter int RATIO_W = `CCRS_RATIO_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ccrs_div_if.div dif
);
  // ==========================================================
  // Counter over 2*ratio core cycles, high for first half
  logic [RATIO_W:0] cnt_r;
  logic [RATIO_W:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [RATIO_W:0] span;

  always_comb begin
    span = {dif.ratio, 1'b0};
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (dif.run && (dif.ratio != '0)) begin
      if (cnt_r >= span - (RATIO_W+1)'(1)) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + (RATIO_W+1)'(1);
      end
      out_nxt = (cnt_nxt < {1'b0, dif.ratio});
    end else begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign dif.clk_out = out_r;

  // ==========================================================
  // Checks: period is ratio peripheral periods
  logic [RATIO_W+1:0] gap_r;
  logic seen_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (!dif.run || $changed(dif.ratio)) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (out_nxt && !out_r) begin
      gap_r <= (RATIO_W+2)'(1);
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + (RATIO_W+2)'(1);
    end
  end

  property p_div_period;
    @(posedge sys_clk) disable iff (sys_rst)
    (seen_r && dif.run && $stable(dif.ratio) && out_nxt && !out_r)
      |-> (gap_r == {1'b0, dif.ratio, 1'b0});
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("divided clock period differs from twice the ratio");

  cover property (@(posedge sys_clk) disable iff (sys_rst)
    seen_r && $rose(out_r));
endmodule // ccrs_divider

// >>> core/ccrs_top.sv
// Functional notes
// - Peripheral clock period is exactly two core clock periods.
// - Serial clock period is peripheral period times the serial divider ratio.
// - SPI clock period is peripheral period times the SPI baud ratio.
// - Ratios 6:1, 16:1, 32:1 supported; software may write others.
// - Core reset released 4096 input clocks plus two core clocks after pin.
// - A missed setup may add one input clock, at most 4097.
// - Initial ratio comes from the two straps sampled during reset.
`include "ccrs_consts.svh"

module ccrs_top import ccrs_pkg::*; #(
  parameter int RST_CYCLES = `CCRS_RST_CYCLES,
  parameter int CNT_W = `CCRS_RST_CNT_W,
  parameter int RATIO_W = `CCRS_RATIO_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic input_clock_pin,
  input wire logic reset_pin_n,
  input wire logic [`CCRS_STRAP_W-1:0] clock_ratio_strap_pins,
  input wire logic power_mgmt_wr,
  input wire logic [`CCRS_MULT_W-1:0] power_mgmt_mult,
  input wire logic [RATIO_W-1:0] serial_divider_field,
  input wire logic [RATIO_W-1:0] spi_baud_register,
  output logic core_reset,
  output logic [`CCRS_MULT_W-1:0] core_mult,
  output logic periph_clk,
  output logic serial_clk,
  output logic spi_clk
);
  // ==========================================================
  // Parameter checks
  generate
    if (RST_CYCLES < 1 || RST_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt
      $error("RST_CYCLES does not fit the counter");
    end
    if (RATIO_W < 2) begin : g_bad_ratio
      $error("RATIO_W too small");
    end
  endgenerate

  // ==========================================================
  // Strap decode
  function automatic logic [`CCRS_MULT_W-1:0] strap_mult(
    input logic [`CCRS_STRAP_W-1:0] s
  );
    case (s)
      `CCRS_STRAP_16: strap_mult = `CCRS_MULT_16;
      `CCRS_STRAP_32: strap_mult = `CCRS_MULT_32;
      `CCRS_STRAP_6: strap_mult = `CCRS_MULT_6;
      default: strap_mult = `CCRS_MULT_DEFAULT;
    endcase
  endfunction

  // ==========================================================
  // Reset sequencer
  ccrs_state_type st_r;
  ccrs_state_type st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [`CCRS_TAIL_W-1:0] tail_r;
  logic [`CCRS_TAIL_W-1:0] tail_nxt;
  logic [`CCRS_MULT_W-1:0] mult_r;
  logic [`CCRS_MULT_W-1:0] mult_nxt;
  logic core_rst_r;
  logic core_rst_nxt;
  logic inclk_d_r;
  logic inclk_rise;

  assign inclk_rise = input_clock_pin & ~inclk_d_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tail_nxt = tail_r;
    mult_nxt = mult_r;
    core_rst_nxt = core_rst_r;
    case (st_r)
      CCRS_ST_HOLD: begin
        core_rst_nxt = 1'b1;
        cnt_nxt = '0;
        tail_nxt = '0;
        mult_nxt = strap_mult(clock_ratio_strap_pins);
        if (reset_pin_n) begin
          st_nxt = CCRS_ST_COUNT;
        end
      end
      CCRS_ST_COUNT: begin
        if (!reset_pin_n) begin
          st_nxt = CCRS_ST_HOLD;
        end else if (inclk_rise) begin
          cnt_nxt = cnt_r + CNT_W'(1);
          if (cnt_nxt == CNT_W'(RST_CYCLES)) begin
            st_nxt = CCRS_ST_TAIL;
          end
        end
      end
      CCRS_ST_TAIL: begin
        tail_nxt = tail_r + `CCRS_TAIL_W'(1);
        if (!reset_pin_n) begin
          st_nxt = CCRS_ST_HOLD;
        end else if (tail_nxt == `CCRS_TAIL_CYCLES) begin
          st_nxt = CCRS_ST_RUN;
          core_rst_nxt = 1'b0;
        end
      end
      CCRS_ST_RUN: begin
        if (!reset_pin_n) begin
          st_nxt = CCRS_ST_HOLD;
          core_rst_nxt = 1'b1;
        end else if (power_mgmt_wr) begin
          mult_nxt = power_mgmt_mult;
        end
      end
      default: begin
        st_nxt = CCRS_ST_HOLD;
        core_rst_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= CCRS_ST_HOLD;
      cnt_r <= '0;
      tail_r <= '0;
      mult_r <= `CCRS_MULT_DEFAULT;
      core_rst_r <= 1'b1;
      inclk_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tail_r <= tail_nxt;
      mult_r <= mult_nxt;
      core_rst_r <= core_rst_nxt;
      inclk_d_r <= input_clock_pin;
    end
  end

  // ==========================================================
  // Peripheral clock, half the core rate
  logic periph_r;
  logic periph_nxt;

  always_comb begin
    periph_nxt = ~periph_r;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_r <= 1'b0;
    end else begin
      periph_r <= periph_nxt;
    end
  end

  // ==========================================================
  // Serial and SPI dividers
  ccrs_div_if #(.RATIO_W(RATIO_W)) sport_if ();
  ccrs_div_if #(.RATIO_W(RATIO_W)) spi_if ();

  assign sport_if.ratio = serial_divider_field;
  assign sport_if.run = ~core_rst_r;
  assign spi_if.ratio = spi_baud_register;
  assign spi_if.run = ~core_rst_r;

  ccrs_divider #(.RATIO_W(RATIO_W)) u_sport_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .dif(sport_if)
  );

  ccrs_divider #(.RATIO_W(RATIO_W)) u_spi_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .dif(spi_if)
  );

  assign core_reset = core_rst_r;
  assign core_mult = mult_r;
  assign periph_clk = periph_r;
  assign serial_clk = sport_if.clk_out;
  assign spi_clk = spi_if.clk_out;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property p_periph_half;
    !$past(sys_rst) |->
      periph_r != $past(periph_r) ##1 periph_r == $past(periph_r, 2);
  endproperty
  a_periph_half: assert property (p_periph_half)
    else $error("peripheral clock not half the core rate");

  property p_release_count;
    $fell(core_rst_r) |->
      cnt_r == CNT_W'(RST_CYCLES) && $past(st_r, 3) == CCRS_ST_COUNT;
  endproperty
  a_release_count: assert property (p_release_count)
    else $error("core reset released at wrong count");

  property p_tail_len;
    (st_r == CCRS_ST_COUNT && st_nxt == CCRS_ST_TAIL) ##1
      reset_pin_n [*2] |-> core_rst_r ##1 !core_rst_r;
  endproperty
  a_tail_len: assert property (p_tail_len)
    else $error("tail after count is not two core cycles");

  property p_max_extra;
    $rose(reset_pin_n) && st_r == CCRS_ST_HOLD |=>
      st_r == CCRS_ST_COUNT && cnt_r == '0;
  endproperty
  a_max_extra: assert property (p_max_extra)
    else $error("count started before first input edge");

  property p_count_bound;
    st_r == CCRS_ST_COUNT |-> cnt_r < CNT_W'(RST_CYCLES);
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("input clock count ran past its limit");

  property p_strap;
    st_r == CCRS_ST_HOLD |=>
      mult_r == strap_mult($past(clock_ratio_strap_pins));
  endproperty
  a_strap: assert property (p_strap)
    else $error("ratio not taken from straps in reset");

  property p_sw_mult;
    st_r == CCRS_ST_RUN && reset_pin_n && power_mgmt_wr |=>
      mult_r == $past(power_mgmt_mult);
  endproperty
  a_sw_mult: assert property (p_sw_mult)
    else $error("software ratio write not applied");

  property p_hold_count;
    st_r == CCRS_ST_COUNT |-> core_rst_r;
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("core left reset while counting");

  property p_pin_reset;
    !reset_pin_n |=> ##1 core_rst_r;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("core reset not asserted after pin low");

  property p_dividers_idle;
    core_rst_r |=> !sport_if.clk_out && !spi_if.clk_out;
  endproperty
  a_dividers_idle: assert property (p_dividers_idle)
    else $error("divided clocks run while core in reset");

  c_release: cover property ($fell(core_rst_r));
  c_sw_write: cover property (st_r == CCRS_ST_RUN && power_mgmt_wr);
  c_abort: cover property (st_r == CCRS_ST_COUNT && !reset_pin_n);
endmodule // ccrs_top

// >>> tb/ccrs_board.sv
`include "ccrs_consts.svh"

module ccrs_board #(
  parameter int HALF = 2,
  parameter int SETUP = 10
) (
  input wire logic sys_clk,
  output logic input_clock_pin,
  output logic reset_pin_n,
  output logic [`CCRS_STRAP_W-1:0] clock_ratio_strap_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;

  initial begin
    input_clock_pin = 1'b0;
    reset_pin_n = 1'b0;
    clock_ratio_strap_pins = 2'h0;
  end

  always @(negedge sys_clk) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      input_clock_pin <= ~input_clock_pin;
    end
  end

  // hold low 4 input clocks, straps settle
  task automatic hold(input logic [`CCRS_STRAP_W-1:0] s);
    @(negedge sys_clk);
    reset_pin_n = 1'b0;
    clock_ratio_strap_pins = s;
    repeat (8 * HALF + SETUP) @(negedge sys_clk);
  endtask

  // Release just after input clock falls, setup met
  task automatic release_pin();
    @(negedge input_clock_pin);
    @(negedge sys_clk);
    reset_pin_n = 1'b1;
  endtask
endmodule // ccrs_board

// >>> tb/tb_top.sv
`include "ccrs_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST = 8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_mgmt_wr = 1'b0;
  logic [5:0] power_mgmt_mult = 6'h00;
  logic [15:0] ser = 16'h0000;
  logic [15:0] spi = 16'h0000;
  logic input_clock_pin, reset_pin_n, core_reset;
  logic periph_clk, serial_clk, spi_clk, pv;
  logic [1:0] straps;
  logic [5:0] core_mult;
  int fail_count = 0;
  int n_checks = 0;
  int n, gap, p;
  logic [5:0] exp_mult [4] = '{`CCRS_MULT_16, `CCRS_MULT_32,
                               `CCRS_MULT_6, `CCRS_MULT_16};

  always #20 sys_clk = ~sys_clk;

  ccrs_board board (.sys_clk(sys_clk), .input_clock_pin(input_clock_pin),
    .reset_pin_n(reset_pin_n), .clock_ratio_strap_pins(straps));

  ccrs_top #(.RST_CYCLES(RST)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .input_clock_pin(input_clock_pin), .reset_pin_n(reset_pin_n),
    .clock_ratio_strap_pins(straps), .power_mgmt_wr(power_mgmt_wr),
    .power_mgmt_mult(power_mgmt_mult), .serial_divider_field(ser),
    .spi_baud_register(spi), .core_reset(core_reset),
    .core_mult(core_mult), .periph_clk(periph_clk),
    .serial_clk(serial_clk), .spi_clk(spi_clk));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic pulse(input logic [5:0] v);
    @(negedge sys_clk);
    power_mgmt_wr = 1'b1;
    power_mgmt_mult = v;
    @(negedge sys_clk);
    power_mgmt_wr = 1'b0;
  endtask

  // Counts input rises and the gap from the last one to release
  task automatic seq();
    logic prev;
    int k;
    prev = input_clock_pin;
    n = 0;
    gap = 0;
    for (k = 0; k < 400 && core_reset !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
      gap++;
      if (input_clock_pin && !prev) begin
        n++;
        gap = 0;
      end
      prev = input_clock_pin;
    end
  endtask

  // Period between the second and third rise of a divided clock
  task automatic meas(input int sel);
    logic q, cv;
    int k, r;
    r = 0;
    p = 0;
    q = 1'b1;
    for (k = 0; k < 200 && r < 3; k++) begin
      @(posedge sys_clk);
      #1;
      cv = sel ? spi_clk : serial_clk;
      if (r == 2) p++;
      if (cv && !q) r++;
      q = cv;
    end
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int s = 0; s < 4; s++) begin
      board.hold(2'(s));
      pulse(6'h3F);
      chk(core_mult, exp_mult[s]);
      chk(core_reset, 1'b1);
      board.release_pin();
      seq();
      chk(n, RST);
      chk(gap >= 2 && gap <= 3, 1'b1);
    end
    board.hold(2'h1);
    board.release_pin();
    repeat (10) @(posedge sys_clk);
    board.hold(2'h1);
    chk(core_reset, 1'b1);
    board.release_pin();
    seq();
    chk(n, RST);
    pv = periph_clk;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #1;
      chk(periph_clk, {~pv});
      pv = periph_clk;
    end
    pulse(6'h2A);
    chk(core_mult, 6'h2A);
    pulse(6'h0C);
    chk(core_mult, 6'h0C);
    for (int r = 1; r < 6; r += 2) begin
      @(negedge sys_clk);
      ser = 16'(r);
      spi = 16'(r + 1);
      meas(0);
      chk(p, 2 * r);
      meas(1);
      chk(p, 2 * (r + 1));
    end
    @(negedge sys_clk);
    ser = 16'h0000;
    spi = 16'h0000;
    repeat (20) @(posedge sys_clk);
    #1;
    chk({serial_clk, spi_clk}, 2'h0);
    report_and_stop();
  end

  // Whole run needs about 500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule // tb_top
